// *** hw/teb_top.sv ***
// line-locked clock generation, receive filter and trunk elastic buffer
// Summary of operation
// - trunk-terminal mode passes frame data through the elastic buffer
// - buffer stores three frames: three octets per B channel, six D bits
// - wander beyond 50 us flags a slip
// - with warn bit set, wander past 25 us raises slip indication
// - bit clock 1536 kHz 6:7, frame sync 8 kHz 1:2, aux 768 kHz outside trunk-terminal mode
// - bit clock derived from master clock by DPLL locked to line
// - low-rate clock 32 kHz when select bit low, 16 kHz when high
// - tracking every 250 us stretches or shortens bit clock high phase
// - derived clocks inherit each tracking step
// - tracked clocks always change on the rising edge of master clock
// - trunk-terminal mode drives bit-rate clock on aux output
// - comparator outputs are oversampled before data detection
// - terminal modes still report line signal during analog loop
// - network or line-termination loop reports no incoming signal
// - each adjustment adds or removes one 50 ns master clock cycle in one bit period
`timescale 1ns/1ps
module teb_top
(
   // clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // configuration
   input wire teb_pkg::teb_mode_e mode_in,
   input wire logic slip_warn_sel_in,
   input wire logic loop_closed_in,
   // line receiver pins
   input wire logic [1:0] line_cmp_in,
   input wire logic line_level_in,
   // line recovery logic
   input wire logic line_frame_in,
   input wire logic line_wr_stb_in,
   input wire teb_pkg::teb_chan_s line_data_in,
   // frame bus
   input wire logic bus_rd_stb_in,
   output teb_pkg::teb_chan_s bus_data_out,
   output logic slip_ind_out,
   output logic slip_out,
   // line-locked clocks
   output logic bit_clock_out,
   output logic frame_sync_out,
   output logic aux_clock_out,
   output logic low_rate_clock_out,
   // receive status
   output logic [1:0] rx_data_out,
   output logic line_signal_out
);
   localparam logic [3:0] DIV = 4'(teb_pkg::BIT_DIV);
   localparam logic [3:0] HIGH = 4'(teb_pkg::BIT_HIGH);
   localparam logic [3:0] ADJ = 4'(teb_pkg::ADJ_CYC);
   localparam logic [8:0] TRK_LAST = 9'(teb_pkg::TRACK_BITS - 1);
   localparam logic [7:0] FRM_LAST = 8'(teb_pkg::FRAME_BITS - 1);
   localparam logic [7:0] FRM_HALF = 8'(teb_pkg::FRAME_BITS / 2);
   localparam logic [7:0] FSC_HI = 8'(teb_pkg::FSC_HIGH_BITS);
   localparam logic [5:0] LR32 = 6'(teb_pkg::LR32_HALF_BITS - 1);
   localparam logic [5:0] LR16 = 6'(teb_pkg::LR16_HALF_BITS - 1);
   localparam logic [2:0] CI_HOLD = 3'(teb_pkg::CI_HOLD_FRAMES);

   logic trunk;
   logic term_mode;
   logic [3:0] ph;
   logic [3:0] per_len;
   logic [3:0] hi_len;
   logic bit_end;
   logic bit_hi;
   logic [1:0] step;
   logic [1:0] dir;
   logic [8:0] trk_cnt;
   logic [7:0] fb_cnt;
   logic aux_t;
   logic [5:0] lr_cnt;
   logic lr;
   logic [1:0] filt_data;
   logic filt_lvl;
   teb_pkg::teb_chan_s eb_data;
   logic eb_warn;
   logic eb_slip;
   teb_pkg::teb_chan_s direct_data;
   logic [2:0] ci_cnt;
   logic ci_load;

   assign trunk = (mode_in == teb_pkg::MODE_TRUNK_TERMINAL);
   assign term_mode = trunk || (mode_in == teb_pkg::MODE_TERMINAL);

   // step[0] lengthens, step[1] shortens the current bit period
   always_comb
   begin
      per_len = DIV;
      hi_len = HIGH;
      if (step[0])
      begin
         per_len = 4'(DIV + ADJ);
         hi_len = 4'(HIGH + ADJ);
      end
      else if (step[1])
      begin
         per_len = 4'(DIV - ADJ);
         hi_len = 4'(HIGH - ADJ);
      end
   end

   assign bit_end = (ph == 4'(per_len - 1'b1));
   assign bit_hi = (ph < hi_len);

   // bit-period phase counter on the master clock
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ph <= '0;
      else if (ce_in)
         ph <= bit_end ? '0 : 4'(ph + 1'b1);
   end

   // tracking interval in bit periods
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         trk_cnt <= '0;
      else if (ce_in && bit_end)
         trk_cnt <= (trk_cnt == TRK_LAST) ? '0 : 9'(trk_cnt + 1'b1);
   end

   // phase detector against the line frame marker
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         dir <= '0;
      else if (ce_in)
      begin
         if (line_frame_in)
         begin
            if (fb_cnt == '0)
               dir <= 2'b00;
            else if (fb_cnt < FRM_HALF)
               dir <= 2'b01;
            else
               dir <= 2'b10;
         end
         else if (bit_end && trk_cnt == TRK_LAST)
            dir <= 2'b00;
      end
   end

   // one adjusted period per tracking interval
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         step <= '0;
      else if (ce_in && bit_end)
         step <= (trk_cnt == TRK_LAST) ? dir : 2'b00;
   end

   // frame, aux and low-rate dividers count bit periods
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         fb_cnt <= '0;
         aux_t <= 1'b0;
      end
      else if (ce_in && bit_end)
      begin
         fb_cnt <= (fb_cnt == FRM_LAST) ? '0 : 8'(fb_cnt + 1'b1);
         aux_t <= !aux_t;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         lr_cnt <= '0;
         lr <= 1'b0;
      end
      else if (ce_in && bit_end)
      begin
         if (lr_cnt >= (slip_warn_sel_in ? LR16 : LR32))
         begin
            lr_cnt <= '0;
            lr <= !lr;
         end
         else
            lr_cnt <= 6'(lr_cnt + 1'b1);
      end
   end

   // registered clock outputs; a step moves edges by the adjust amount
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bit_clock_out <= 1'b0;
         frame_sync_out <= 1'b0;
         aux_clock_out <= 1'b0;
         low_rate_clock_out <= 1'b0;
      end
      else if (ce_in)
      begin
         bit_clock_out <= bit_hi;
         frame_sync_out <= (fb_cnt < FSC_HI);
         aux_clock_out <= trunk ? bit_hi : !aux_t;
         low_rate_clock_out <= lr;
      end
   end

   teb_rx_filter #(.TAPS(teb_pkg::OVS_TAPS)) u_filter
   (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .cmp_in(line_cmp_in),
      .lvl_in(line_level_in),
      .data_out(filt_data),
      .lvl_out(filt_lvl)
   );

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_data_out <= '0;
         line_signal_out <= 1'b0;
      end
      else if (ce_in)
      begin
         rx_data_out <= filt_data;
         line_signal_out <= filt_lvl && (term_mode || !loop_closed_in);
      end
   end

   teb_elastic #(.DEPTH(teb_pkg::EB_DEPTH)) u_elastic
   (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .wr_stb_in(line_wr_stb_in && trunk),
      .wr_data_in(line_data_in),
      .rd_stb_in(bus_rd_stb_in && trunk),
      .rd_data_out(eb_data),
      .warn_out(eb_warn),
      .slip_out(eb_slip)
   );

   // bus data: buffered in trunk mode, direct otherwise
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         direct_data <= '0;
      else if (ce_in && !trunk && line_wr_stb_in)
         direct_data <= line_data_in;
   end

   always_comb
   begin
      if (trunk)
         bus_data_out = eb_data;
      else
         bus_data_out = direct_data;
   end

   // slip warning held across bus frames; a new warning wins over the count
   assign ci_load = eb_warn && slip_warn_sel_in;

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ci_cnt <= '0;
         slip_ind_out <= 1'b0;
         slip_out <= 1'b0;
      end
      else if (ce_in)
      begin
         if (ci_load)
            ci_cnt <= CI_HOLD;
         else if (bus_rd_stb_in && ci_cnt != '0)
            ci_cnt <= 3'(ci_cnt - 1'b1);
         slip_ind_out <= ci_load || (ci_cnt != '0);
         slip_out <= eb_slip;
      end
   end

   property p_bit_high;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      $rose(bit_clock_out) |-> bit_clock_out[*5] ##[1:3] !bit_clock_out;
   endproperty
   a_bit_high: assert property (p_bit_high)
      else $error("bit clock high phase out of range");

   property p_bit_low;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      $fell(bit_clock_out) |-> !bit_clock_out[*7] ##1 bit_clock_out;
   endproperty
   a_bit_low: assert property (p_bit_low)
      else $error("bit clock low phase not seven cycles");

   property p_step_spacing;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (step != 2'b00) |-> (trk_cnt == '0);
   endproperty
   a_step_spacing: assert property (p_step_spacing)
      else $error("tracking step outside interval boundary");

   property p_aux_trunk;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      trunk ##1 trunk |-> (aux_clock_out == bit_clock_out);
   endproperty
   a_aux_trunk: assert property (p_aux_trunk)
      else $error("aux clock not bit clock in trunk mode");

   property p_loop_quiet;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      (loop_closed_in && !term_mode) |=> !line_signal_out;
   endproperty
   a_loop_quiet: assert property (p_loop_quiet)
      else $error("line signal reported in own loop");

   property p_loop_seen;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      (loop_closed_in && term_mode && filt_lvl) |=> line_signal_out;
   endproperty
   a_loop_seen: assert property (p_loop_seen)
      else $error("line signal lost during terminal loop");

   property p_warn_ind;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      (eb_warn && slip_warn_sel_in) |=> slip_ind_out [*2];
   endproperty
   a_warn_ind: assert property (p_warn_ind)
      else $error("slip warning not indicated");

   property p_ind_hold;
      @(posedge ref_clk_in) disable iff (!rst_n_in || !ce_in)
      (slip_ind_out && !bus_rd_stb_in && !$past(bus_rd_stb_in)) |=> slip_ind_out;
   endproperty
   a_ind_hold: assert property (p_ind_hold)
      else $error("slip indication dropped between frames");

   c_step_up: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) step[0]);
   c_step_dn: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) step[1]);
   c_ind: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(slip_ind_out));
endmodule : teb_top

// *** hw/teb_pkg.sv ***
// constants and types shared by the trunk elastic buffer and clock block
package teb_pkg;
   localparam int REF_CLK_KHZ = 20000;
   localparam int BIT_CLK_KHZ = 1536;
   localparam int MCLK_HALF_NS = 65;
   localparam int TRACK_US = 250;
   localparam int FRAME_US = 125;
   localparam int WANDER_US = 50;
   localparam int WARN_US = 25;
   localparam int BIT_DIV = REF_CLK_KHZ / BIT_CLK_KHZ;
   localparam int BIT_HIGH = BIT_DIV / 2;
   localparam int ADJ_CYC_RAW = MCLK_HALF_NS * REF_CLK_KHZ / 1000000;
   localparam int ADJ_CYC = (ADJ_CYC_RAW < 1) ? 1 : ADJ_CYC_RAW;
   localparam int TRACK_BITS = TRACK_US * BIT_CLK_KHZ / 1000;
   localparam int FRAME_BITS = BIT_CLK_KHZ / 8;
   localparam int FSC_HIGH_BITS = FRAME_BITS / 3;
   localparam int LR32_HALF_BITS = BIT_CLK_KHZ / (2 * 32);
   localparam int LR16_HALF_BITS = BIT_CLK_KHZ / (2 * 16);
   localparam int FRAME_CYC = FRAME_US * REF_CLK_KHZ / 1000;
   localparam int WANDER_CYC = WANDER_US * REF_CLK_KHZ / 1000;
   localparam int WARN_CYC = WARN_US * REF_CLK_KHZ / 1000;
   localparam int EB_DEPTH = 3;
   localparam int EB_CENTRE = 1;
   localparam int CI_HOLD_FRAMES = 4;
   localparam int OVS_TAPS = 3;

   typedef enum logic [1:0] {
      MODE_TERMINAL,
      MODE_TRUNK_TERMINAL,
      MODE_NETWORK_TERM,
      MODE_LINE_TERM_S
   } teb_mode_e;

   // one frame worth of channel data
   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] d;
   } teb_chan_s;
endpackage : teb_pkg

// *** hw/teb_rx_filter.sv ***
// receive comparator oversampling and level input filter
`timescale 1ns/1ps
module teb_rx_filter #(parameter int TAPS = teb_pkg::OVS_TAPS)
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // raw pins
   input wire logic [1:0] cmp_in,
   input wire logic lvl_in,
   // filtered
   output logic [1:0] data_out,
   output logic lvl_out
);
   logic [2:0] raw;
   logic [2:0] filt;

   assign raw = {lvl_in, cmp_in};

   for (genvar i = 0; i < 3; i++)
   begin : g_bit
      logic s1;
      logic s2;
      logic [TAPS-1:0] sh;
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
         begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            sh <= '0;
            filt[i] <= 1'b0;
         end
         else if (ce_in)
         begin
            s1 <= raw[i];
            s2 <= s1;
            sh <= {sh[TAPS-2:0], s2};
            filt[i] <= ($countones(sh) > (TAPS / 2));
         end
      end
   end

   assign data_out = filt[1:0];
   assign lvl_out = filt[2];
endmodule : teb_rx_filter

// *** hw/teb_elastic.sv ***
// frame elastic store between line side and frame bus with slip detection
`timescale 1ns/1ps
module teb_elastic #(parameter int DEPTH = teb_pkg::EB_DEPTH)
(
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // line side write
   input wire logic wr_stb_in,
   input wire teb_pkg::teb_chan_s wr_data_in,
   // frame bus read
   input wire logic rd_stb_in,
   output teb_pkg::teb_chan_s rd_data_out,
   // status
   output logic warn_out,
   output logic slip_out
);
   localparam int PW = $clog2(DEPTH);
   localparam logic signed [12:0] HALF = 13'(teb_pkg::FRAME_CYC / 2);
   localparam logic signed [12:0] FULL = 13'(teb_pkg::FRAME_CYC);
   localparam logic [12:0] LIM = 13'(teb_pkg::WANDER_CYC);
   localparam logic [12:0] WRN = 13'(teb_pkg::WARN_CYC);
   localparam logic [11:0] SAT = 12'(teb_pkg::FRAME_CYC);

   teb_pkg::teb_chan_s mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] next_wr;
   logic [PW:0] fill;
   logic [11:0] since_wr;
   logic [11:0] ref_ph;
   logic signed [12:0] dev;
   logic [12:0] dev_abs;
   logic slip_now;
   logic over;
   logic under;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : inc

   function automatic logic [PW-1:0] back(input logic [PW-1:0] p);
      return (p >= PW'(teb_pkg::EB_CENTRE)) ? PW'(p - PW'(teb_pkg::EB_CENTRE))
         : PW'(p + PW'(DEPTH - teb_pkg::EB_CENTRE));
   endfunction : back

   // phase of read against write, folded into one frame
   always_comb
   begin
      dev = $signed({1'b0, since_wr}) - $signed({1'b0, ref_ph});
      if (dev > HALF)
         dev = dev - FULL;
      else if (dev < -HALF)
         dev = dev + FULL;
      dev_abs = (dev < 0) ? 13'(-dev) : 13'(dev);
   end

   assign next_wr = wr_stb_in ? inc(wr_ptr) : wr_ptr;
   assign over = wr_stb_in && !rd_stb_in && (fill == (PW + 1)'(DEPTH));
   assign under = rd_stb_in && !wr_stb_in && (fill == '0);
   assign slip_now = over || under || (rd_stb_in && (dev_abs > LIM));

   for (genvar e = 0; e < DEPTH; e++)
   begin : g_entry
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
            mem[e] <= '0;
         else if (ce_in && wr_stb_in && (wr_ptr == PW'(e)))
            mem[e] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         since_wr <= '0;
      else if (ce_in)
         since_wr <= wr_stb_in ? '0 : ((since_wr == SAT) ? SAT : 12'(since_wr + 1'b1));
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
         ref_ph <= '0;
         rd_data_out <= '0;
         warn_out <= 1'b0;
         slip_out <= 1'b0;
      end
      else if (ce_in)
      begin
         wr_ptr <= next_wr;
         if (rd_stb_in)
            rd_data_out <= mem[rd_ptr];
         warn_out <= rd_stb_in && (dev_abs > WRN);
         slip_out <= slip_now;
         if (slip_now)
         begin
            rd_ptr <= back(next_wr);
            fill <= (PW + 1)'(teb_pkg::EB_CENTRE);
            ref_ph <= since_wr;
         end
         else
         begin
            if (rd_stb_in)
               rd_ptr <= inc(rd_ptr);
            fill <= (PW + 1)'(fill + wr_stb_in - rd_stb_in);
         end
      end
   end

   property p_fill_bound;
      @(posedge clk_in) disable iff (!rst_n_in)
      fill <= (PW + 1)'(DEPTH);
   endproperty
   a_fill_bound: assert property (p_fill_bound)
      else $error("elastic fill above depth");

   property p_recentre;
      @(posedge clk_in) disable iff (!rst_n_in)
      slip_out |-> (fill == (PW + 1)'(teb_pkg::EB_CENTRE));
   endproperty
   a_recentre: assert property (p_recentre)
      else $error("slip did not recentre buffer");

   property p_slip_flag;
      @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
      (rd_stb_in && dev_abs > LIM) |=> slip_out;
   endproperty
   a_slip_flag: assert property (p_slip_flag)
      else $error("wander past limit not flagged");

   c_slip: cover property (@(posedge clk_in) disable iff (!rst_n_in) slip_out);
endmodule : teb_elastic

// *** dv/teb_bus_model.sv ***
// frame bus controller model issuing one read strobe per bus frame
`timescale 1ns/1ps
module teb_bus_model #(parameter int PERIOD = teb_pkg::FRAME_CYC)
(
   // clock, reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control, low suppresses the read strobe while the frame count runs on
   input wire logic en_in,
   // frame bus
   output logic rd_stb_out
);
   int cnt;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt <= 0;
         rd_stb_out <= 1'b0;
      end
      else
      begin
         rd_stb_out <= en_in && (cnt == PERIOD - 1);
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      end
   end
endmodule : teb_bus_model

// *** dv/tb_top.sv ***
// self-checking bench for the elastic buffer and clock block
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   teb_pkg::teb_mode_e mode_in = teb_pkg::MODE_TERMINAL;
   logic sel = 1'b0;
   logic loop_in = 1'b0;
   logic [1:0] cmp = 2'h0;
   logic lvl = 1'b0;
   logic frm = 1'b0;
   logic wr = 1'b0;
   teb_pkg::teb_chan_s wdata = '0;
   logic rd;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   teb_pkg::teb_chan_s bus_data;
   logic slip_ind, slip, bclk, fsync, aux, lrc, lsig, stb_seen;
   logic [1:0] rxd;
   logic [1:0] rd_d = 2'h0;
   teb_pkg::teb_chan_s exp_q[$];
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int slip_cnt = 0;
   int ind_rd = 0;
   int ind_seen = 0;
   int ind_base = 0;
   int wr_ofs = 1200;
   logic burst = 1'b0;
   logic eb_chk = 1'b0;
   teb_pkg::teb_chan_s nxt;
   teb_pkg::teb_chan_s eb_q[$];

   always #25 ref_clk_in = ~ref_clk_in;

   teb_top i_teb_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .mode_in(mode_in), .slip_warn_sel_in(sel), .loop_closed_in(loop_in),
      .line_cmp_in(cmp), .line_level_in(lvl), .line_frame_in(frm),
      .line_wr_stb_in(wr), .line_data_in(wdata), .bus_rd_stb_in(rd),
      .bus_data_out(bus_data), .slip_ind_out(slip_ind), .slip_out(slip),
      .bit_clock_out(bclk), .frame_sync_out(fsync), .aux_clock_out(aux),
      .low_rate_clock_out(lrc), .rx_data_out(rxd), .line_signal_out(lsig));

   teb_bus_model i_teb_bus_model (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .en_in(rd_en),
      .rd_stb_out(rd));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report;
      if (error_cnt == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   // cycle ceiling
   always @(posedge ref_clk_in)
      if (cyc == 90000)
      begin
         error_cnt++;
         final_report();
      end

   // line recovery side: frame marker and one frame word per line frame
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      frm <= (cyc % 2500 == 300);
      if (burst || (wr_en && (cyc % 2500 == wr_ofs)))
      begin
         nxt = 18'($urandom);
         wr <= 1'b1;
         wdata <= nxt;
         if (mode_in != teb_pkg::MODE_TRUNK_TERMINAL)
            exp_q.push_back(nxt);
         else
            eb_q.push_back(nxt);
      end
      else
         wr <= 1'b0;
   end

   // output watcher
   always @(posedge ref_clk_in)
   begin
      stb_seen <= wr && mode_in != teb_pkg::MODE_TRUNK_TERMINAL;
      rd_d <= {rd_d[0], rd};
      if (rd && slip_ind === 1'b1)
         ind_rd <= ind_rd + 1;
   end

   always @(negedge ref_clk_in)
   begin
      if (stb_seen === 1'b1 && exp_q.size() > 0)
         chk(bus_data, exp_q.pop_front());
      // buffered read returns the word one frame behind the newest
      if (rd_d[0] === 1'b1 && mode_in == teb_pkg::MODE_TRUNK_TERMINAL)
      begin
         while (eb_q.size() > 2)
            void'(eb_q.pop_front());
         if (eb_chk === 1'b1 && eb_q.size() == 2)
            chk(bus_data, eb_q.pop_front());
      end
      if (slip === 1'b1)
      begin
         slip_cnt++;
         chk(rd_d[1], 1'b1);
      end
      if (slip_ind === 1'b1)
         ind_seen++;
   end

   task automatic measure(input int aux_exp, input int lr_exp);
      int bits, auxr, fsh, hi, per, lrb, lrn;
      logic pb, pa, pf, pl;
      pf = 1'b1;
      while (!(fsync === 1'b1 && pf === 1'b0))
      begin
         pf = fsync;
         @(negedge ref_clk_in);
      end
      bits = 0; auxr = 0; fsh = 0; hi = 0; per = 0; lrb = 0; lrn = 0;
      pb = bclk; pa = aux; pl = lrc; pf = fsync;
      do
      begin
         @(negedge ref_clk_in);
         if (aux_exp == 192)
            chk(aux, bclk);
         if (bclk === 1'b1 && pb === 1'b0)
         begin
            if (bits > 0)
            begin
               chk(per - hi, 7);
               chk(hi >= 5 && hi <= 7, 1'b1);
            end
            bits++; lrb++; per = 1; hi = 1;
            if (fsync === 1'b1)
               fsh++;
         end
         else
         begin
            per++;
            hi += (bclk === 1'b1);
         end
         if (aux === 1'b1 && pa === 1'b0)
            auxr++;
         if (lrc !== pl)
         begin
            if (lrn > 0)
               chk(lrb, lr_exp);
            lrn++;
            lrb = 0;
         end
         pb = bclk; pa = aux; pl = lrc;
         if (fsync === 1'b1 && pf === 1'b0)
            break;
         pf = fsync;
      end
      while (1);
      chk(bits, 192);
      chk(fsh, 64);
      chk(auxr, aux_exp);
   endtask : measure

   task automatic level_case(input teb_pkg::teb_mode_e m, input logic lp, input logic e);
      @(posedge ref_clk_in);
      mode_in <= m;
      loop_in <= lp;
      repeat (10) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(lsig, e);
   endtask : level_case

   task automatic run_frames(input int n);
      repeat (n * 2500) @(posedge ref_clk_in);
   endtask : run_frames

   initial
   begin
      void'($urandom(12906));
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      wr_en <= 1'b1;
      measure(96, 24);
      @(posedge ref_clk_in);
      sel <= 1'b1;
      measure(96, 48);
      // back to back frame words
      @(posedge ref_clk_in);
      burst <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      burst <= 1'b0;
      @(posedge ref_clk_in);
      wr_en <= 1'b0;
      lvl <= 1'b1;
      level_case(teb_pkg::MODE_TERMINAL, 1'b1, 1'b1);
      level_case(teb_pkg::MODE_NETWORK_TERM, 1'b1, 1'b0);
      level_case(teb_pkg::MODE_LINE_TERM_S, 1'b1, 1'b0);
      level_case(teb_pkg::MODE_NETWORK_TERM, 1'b0, 1'b1);
      level_case(teb_pkg::MODE_TRUNK_TERMINAL, 1'b1, 1'b1);
      // single-cycle comparator glitch must not pass the filter
      @(posedge ref_clk_in);
      cmp <= 2'h3;
      @(posedge ref_clk_in);
      cmp <= 2'h0;
      repeat (10)
      begin
         @(negedge ref_clk_in);
         chk(rxd, 2'h0);
      end
      @(posedge ref_clk_in);
      cmp <= 2'h2;
      repeat (10) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(rxd, 2'h2);
      measure(192, 48);
      // underflow slips without the warning bit
      @(posedge ref_clk_in);
      sel <= 1'b0;
      rd_en <= 1'b1;
      run_frames(6);
      chk(slip_cnt > 0, 1'b1);
      chk(ind_seen, 0);
      // line words resume with warning on: first reads slip to the centre
      sel <= 1'b1;
      wr_en <= 1'b1;
      slip_cnt = 0;
      run_frames(6);
      chk(slip_cnt > 0, 1'b1);
      // steady line and bus rates stay within the buffer
      slip_cnt = 0;
      eb_chk <= 1'b1;
      run_frames(4);
      chk(slip_cnt, 0);
      // 35 us of wander warns without losing data
      eb_chk <= 1'b0;
      ind_base = ind_rd;
      wr_ofs <= 1900;
      run_frames(4);
      chk(slip_cnt, 0);
      chk(ind_rd - ind_base >= 2, 1'b1);
      final_report();
   end
endmodule : tb_top
